// ---- inc/iacr_pkg.sv ----
package iacr_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned PHASE_W = 9;

    // ------------------------------------------------------------
    // clock phase tables, indexed by the period select code
    // ------------------------------------------------------------
    localparam logic [8:0] HIGH_CYC [8] = '{9'h009, 9'h00B, 9'h00F, 9'h017,
                                            9'h027, 9'h047, 9'h087, 9'h107};
    localparam logic [8:0] LOW_CYC [8] = '{9'h00C, 9'h00E, 9'h012, 9'h01A,
                                           9'h02A, 9'h04A, 9'h08A, 9'h10A};

    // ------------------------------------------------------------
    // word framing
    // ------------------------------------------------------------
    localparam logic [3:0] FULL_WORD_BITS = 4'h8;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [2:0] MSB_IDX = 3'h7;

    // external clock minimum phases, in clock cycles
    localparam int unsigned EXT_MIN_HIGH = 3;
    localparam int unsigned EXT_MIN_LOW = 5;

    typedef struct packed {
        logic ack_mode;
        logic [2:0] word_bit_count;
        logic [2:0] period_sel;
        logic address_detect_off;
        logic free_format_sel;
        logic [6:0] own_slave_addr;
    } iacr_ctrl_t;

    // last count value of a phase (length minus one)
    function automatic logic [8:0] phase_last(input logic [2:0] sel, input logic high);
        phase_last = high ? HIGH_CYC[sel] - 9'h001 : LOW_CYC[sel] - 9'h001;
    endfunction

    // code 000 stands for a full word
    function automatic logic [3:0] word_bits(input logic [2:0] bc);
        word_bits = (bc == 3'h0) ? FULL_WORD_BITS : {1'b0, bc};
    endfunction

endpackage

// ---- logic/iacr_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser; stage one is seen by stage two only
module iacr_sync #(
    parameter int unsigned W = 2,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta <= INIT;
            o_sync <= INIT;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

`default_nettype wire

// ---- logic/iacr_core.sv ----
`timescale 1ns/1ns
`default_nettype none

module iacr_core (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire iacr_pkg::iacr_ctrl_t i_ctrl,
    input wire logic i_role_wr,
    input wire logic i_role_master,
    input wire logic i_role_transmit,
    input wire logic i_release,
    input wire logic [7:0] i_tx_data,
    input wire logic i_start_req,
    input wire logic i_stop_req,
    input wire logic i_arb_lost,
    input wire logic i_scl_pin,
    input wire logic i_sda_pin,
    output logic o_master_select,
    output logic o_transmit_select,
    output logic o_pending,
    output logic o_word_done,
    output logic [7:0] o_rx_byte,
    output logic o_last_bit,
    output logic o_bus_busy,
    output logic o_addressed,
    output logic o_scl_out,
    output logic o_scl_oe,
    output logic o_sda_out,
    output logic o_sda_oe
);
    import iacr_pkg::*;

    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_START = 8'h02,
        S_LOW = 8'h04,
        S_WAIT = 8'h08,
        S_HIGH = 8'h10,
        S_STOP_LOW = 8'h20,
        S_STOP_WAIT = 8'h40,
        S_STOP_SETUP = 8'h80
    } iacr_state_t;

    // ------------------------------------------------------------
    // bus sensing
    // ------------------------------------------------------------
    logic scl_s, sda_s, scl_q, sda_q;
    logic scl_rise, scl_fall, start_det, stop_det;

    // edges are found on the synchronised level; external phases
    // of 3 high and 5 low cycles leave margin for the two-stage lag
    iacr_sync #(.W(2), .INIT(2'h3)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_scl_pin, i_sda_pin}),
        .o_sync({scl_s, sda_s})
    );

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

    // ------------------------------------------------------------
    // word framing
    // ------------------------------------------------------------
    iacr_state_t st;
    logic [8:0] phase_cnt, hold_cnt, t_high, t_low;
    logic busy, first_word, ack_slot, sda_low, addressed, pending, slave_hold;
    logic master, transmit_select, stop_q;
    logic [3:0] bit_cnt, nbits, total;
    logic [7:0] rx_shift, tx_shift;
    logic act_tx, addr_hit, next_is_ack, ack_low, wd, irq_word;

    assign t_high = phase_last(i_ctrl.period_sel, 1'b1);
    assign t_low = phase_last(i_ctrl.period_sel, 1'b0);

    // the address word is always a full word
    assign nbits = first_word ? FULL_WORD_BITS : word_bits(i_ctrl.word_bit_count);
    assign total = nbits + {3'h0, i_ctrl.ack_mode};
    assign wd = scl_fall & busy & (bit_cnt == total);
    assign next_is_ack = i_ctrl.ack_mode & (bit_cnt == nbits);
    assign act_tx = transmit_select & (master | addressed);
    assign addr_hit = ~i_ctrl.free_format_sel & ~i_ctrl.address_detect_off & ~master
                      & first_word & ((rx_shift[7:1] == i_ctrl.own_slave_addr)
                      | (rx_shift[7:1] == GEN_CALL_ADDR));
    assign irq_word = master | addressed;

    always_comb begin
        if (master) begin
            ack_low = ~transmit_select;
        end else if (first_word & ~i_ctrl.free_format_sel) begin
            ack_low = addr_hit;
        end else begin
            ack_low = addressed & ~transmit_select;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy <= 1'b0;
            first_word <= 1'b0;
            bit_cnt <= 4'h0;
            ack_slot <= 1'b0;
        end else if (start_det) begin
            busy <= 1'b1;
            first_word <= 1'b1;
            bit_cnt <= 4'h0;
            ack_slot <= 1'b0;
        end else if (stop_det) begin
            busy <= 1'b0;
            first_word <= 1'b0;
            bit_cnt <= 4'h0;
            ack_slot <= 1'b0;
        end else if (wd) begin
            first_word <= 1'b0;
            bit_cnt <= 4'h0;
            ack_slot <= 1'b0;
        end else if (busy & scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
        end else if (busy & scl_fall) begin
            ack_slot <= next_is_ack;
        end
    end

    // received bits; the ack bit is kept apart from the data byte
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_shift <= 8'h00;
            o_last_bit <= 1'b0;
        end else if (busy & scl_rise) begin
            o_last_bit <= sda_s;
            if (!ack_slot) begin
                rx_shift <= {rx_shift[6:0], sda_s};
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_shift <= 8'h00;
        end else if (i_release) begin
            tx_shift <= i_tx_data;
        end
    end

    // ------------------------------------------------------------
    // data pin drive
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sda_low <= 1'b0;
        end else if (i_arb_lost | stop_det) begin
            sda_low <= 1'b0;
        end else if (start_det) begin
            // own start keeps data low until the first bit is set up
            sda_low <= (st == S_START);
        end else if (busy & scl_fall) begin
            if (wd) begin
                sda_low <= 1'b0;
            end else if (next_is_ack) begin
                sda_low <= ack_low;
            end else begin
                sda_low <= act_tx & ~tx_shift[3'(MSB_IDX - bit_cnt[2:0])];
            end
        end else if (i_release & busy & ~ack_slot) begin
            // word boundary: the first bit follows the new data
            sda_low <= act_tx & ~i_tx_data[7];
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_low | (st == S_START) | (st == S_STOP_LOW)
                      | (st == S_STOP_WAIT) | (st == S_STOP_SETUP);

    // ------------------------------------------------------------
    // roles and addressing
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            master <= 1'b0;
        end else if (stop_det | i_arb_lost) begin
            master <= 1'b0;
        end else if (i_role_wr) begin
            master <= i_role_master;
        end
    end

    // hardware clears win over a software write in the same cycle
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            transmit_select <= 1'b0;
        end else if (stop_det | i_arb_lost) begin
            transmit_select <= 1'b0;
        end else if (i_role_wr) begin
            transmit_select <= i_role_transmit;
        end else if (busy & scl_rise & ack_slot & first_word) begin
            if (master & ~i_ctrl.free_format_sel & ~sda_s) begin
                transmit_select <= ~tx_shift[0];
            end else if (addr_hit) begin
                transmit_select <= rx_shift[0];
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            addressed <= 1'b0;
        end else if (start_det) begin
            addressed <= i_ctrl.free_format_sel & ~master;
        end else if (stop_det) begin
            addressed <= 1'b0;
        end else if (busy & scl_rise & ack_slot & addr_hit) begin
            addressed <= 1'b1;
        end
    end

    // pending flag: word end as master or addressed slave clears it, software release sets it
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pending <= 1'b1;
            o_word_done <= 1'b0;
        end else begin
            o_word_done <= wd & irq_word;
            if (wd & irq_word) begin
                pending <= 1'b0;
            end else if (i_release) begin
                pending <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // slave clock hold
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            slave_hold <= 1'b0;
            hold_cnt <= 9'h000;
        end else if (wd & irq_word & ~master) begin
            slave_hold <= 1'b1;
            hold_cnt <= 9'h000;
        end else if (slave_hold & ~pending) begin
            hold_cnt <= 9'h000;
        end else if (slave_hold) begin
            hold_cnt <= hold_cnt + 9'h001;
            if (hold_cnt == t_low) begin
                slave_hold <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // master clock generator
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stop_q <= 1'b0;
        end else if (st == S_STOP_LOW) begin
            stop_q <= 1'b0;
        end else if (i_stop_req) begin
            stop_q <= 1'b1;
        end
    end

    // level compared every cycle so a stretched or shared clock is followed
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= S_IDLE;
            phase_cnt <= 9'h000;
        end else if (!master && st != S_IDLE) begin
            st <= S_IDLE;
            phase_cnt <= 9'h000;
        end else begin
            phase_cnt <= phase_cnt + 9'h001;
            unique case (st)
                S_IDLE: begin
                    phase_cnt <= 9'h000;
                    if (i_start_req && !busy) begin
                        st <= S_START;
                    end
                end
                S_START: begin
                    if (phase_cnt == t_high) begin
                        st <= S_LOW;
                        phase_cnt <= 9'h000;
                    end
                end
                S_LOW: begin
                    if (i_release) begin
                        phase_cnt <= 9'h000;
                    end else if (phase_cnt >= t_low) begin
                        phase_cnt <= t_low;
                        if (pending) begin
                            st <= stop_q ? S_STOP_LOW : S_WAIT;
                            phase_cnt <= 9'h000;
                        end
                    end
                end
                S_WAIT: begin
                    phase_cnt <= 9'h000;
                    if (scl_s) begin
                        st <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    if (!scl_s || phase_cnt == t_high) begin
                        st <= S_LOW;
                        phase_cnt <= 9'h000;
                    end
                end
                S_STOP_LOW: begin
                    if (phase_cnt == t_low) begin
                        st <= S_STOP_WAIT;
                        phase_cnt <= 9'h000;
                    end
                end
                S_STOP_WAIT: begin
                    phase_cnt <= 9'h000;
                    if (scl_s) begin
                        st <= S_STOP_SETUP;
                    end
                end
                S_STOP_SETUP: begin
                    if (phase_cnt == t_high) begin
                        st <= S_IDLE;
                        phase_cnt <= 9'h000;
                    end
                end
                default: begin
                    st <= S_IDLE;
                    phase_cnt <= 9'h000;
                end
            endcase
        end
    end

    assign o_scl_out = 1'b0;
    assign o_scl_oe = (st == S_LOW) | (st == S_STOP_LOW) | slave_hold;
    assign o_master_select = master;
    assign o_transmit_select = transmit_select;
    assign o_pending = pending;
    assign o_rx_byte = rx_shift;
    assign o_bus_busy = busy;
    assign o_addressed = addressed;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_ack_mtx_rel: assert property (
        (master && transmit_select && ack_slot && !first_word && st != S_STOP_LOW) |-> !o_sda_oe)
        else $error("master transmitter drives data in ack slot");
    a_ack_mrx_low: assert property (
        (master && !transmit_select && ack_slot && !first_word) |-> o_sda_oe)
        else $error("master receiver does not ack");
    a_ack_slave_hit: assert property (
        (busy && scl_fall && !wd && next_is_ack && addr_hit && !i_arb_lost) |=> sda_low)
        else $error("slave misses address ack");
    a_ack_off_none: assert property (
        (!i_ctrl.ack_mode && !ack_slot && $stable(i_ctrl.ack_mode)) |=> !ack_slot)
        else $error("ack slot without ack mode");
    a_start_hold: assert property (
        (st == S_START && phase_cnt == 9'h000 && master && $stable(i_ctrl))
        |-> (st == S_START) [*3])
        else $error("start hold too short");
    a_high_restart: assert property (
        (st == S_HIGH && !scl_s && master && !i_arb_lost)
        |=> (st == S_LOW && phase_cnt == 9'h000))
        else $error("high count not restarted on low bus");
    a_wait_high: assert property (
        (st == S_WAIT && !scl_s && master && !i_arb_lost) |=> (st == S_WAIT))
        else $error("high count began with bus low");
    a_high_end: assert property (
        (st == S_HIGH && scl_s && phase_cnt == t_high && master && !i_arb_lost)
        |=> (st == S_LOW) ##1 o_scl_oe)
        else $error("clock not driven low after high count");
    a_stop_clears: assert property (
        (stop_det || i_arb_lost) |=> (!master && !transmit_select))
        else $error("roles not cleared on stop or loss");
    a_pend_clear: assert property (
        (wd && irq_word) |=> (!pending && o_word_done))
        else $error("pending not cleared at word end");
    a_hold_low: assert property (
        (slave_hold && $rose(pending)) |-> o_scl_oe [*8])
        else $error("slave clock released early");
    a_free_trx: assert property (
        (i_ctrl.free_format_sel && !i_role_wr && !stop_det && !i_arb_lost
         && $stable(i_ctrl.free_format_sel)) |=> $stable(transmit_select))
        else $error("transmit changed in free format");
    a_adoff_trx: assert property (
        (!master && i_ctrl.address_detect_off && !i_role_wr && !stop_det
         && !i_arb_lost) |=> $stable(transmit_select))
        else $error("transmit changed with address detect off");

    c_start: cover property (start_det && st == S_START);
    c_word: cover property (o_word_done && master);
    c_sync: cover property (st == S_HIGH && !scl_s && phase_cnt != t_high);
    c_slave_rel: cover property ($fell(slave_hold));
    c_stop: cover property (st == S_STOP_SETUP ##1 st == S_IDLE);
endmodule

`default_nettype wire

// ---- bench/iacr_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ----
// far party: acking slave and 80 ns clocking master
// ----
module iacr_bus_model (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_low,
    output logic o_sda_low
);
    logic ack_en = 1'b0;
    logic sda_s = 1'b0;
    logic sda_m = 1'b0;
    logic [7:0] rxb = 8'h00;
    int nbit = 0;
    initial o_scl_low = 1'b0;
    assign o_sda_low = sda_s | sda_m;
    always @(negedge i_sda) if (i_scl) nbit = 0;
    always @(posedge i_scl) begin
        if (nbit < 8) rxb = {rxb[6:0], i_sda};
        nbit = nbit + 1;
    end
    // ack spans the fall after bit 8 up to the next fall
    always @(negedge i_scl) sda_s = ack_en && nbit == 8;
    task automatic start_frame();
        sda_m = 1'b1;
        #40 o_scl_low = 1'b1;
    endtask
    // waits on the bus level, so a stretching device is honoured
    task automatic send_byte(input logic [7:0] b, output logic acked);
        for (int i = 7; i >= -1; i--) begin
            #10 sda_m = (i >= 0) ? ~b[i] : 1'b0;
            #30 o_scl_low = 1'b0;
            wait (i_scl);
            if (i < 0) acked = ~i_sda;
            #40 o_scl_low = 1'b1;
        end
    endtask
    task automatic free_clk();
        o_scl_low = 1'b0;
        sda_m = 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb;
    import iacr_pkg::*;
    // ----
    // bench state
    // ----
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    iacr_ctrl_t ctrl = '{ack_mode: 1'b1, own_slave_addr: 7'h5A, default: '0};
    logic role_wr = 1'b0, role_m = 1'b0, role_t = 1'b0, rel = 1'b0, start = 1'b0, arb = 1'b0;
    logic stp = 1'b0;
    logic [7:0] txd = 8'h00;
    logic [7:0] rxd;
    logic m_sel, t_sel, pend, wdone, addr_hit, scl_oe, sda_oe, pm_scl, pm_sda, ack;
    logic scl_bus, sda_bus;
    int miscompares = 0, checked = 0, cyc = 0, n = 0;
    int hi_t [8] = '{9, 11, 15, 23, 39, 71, 135, 263};
    int lo_t [8] = '{12, 14, 18, 26, 42, 74, 138, 266};
    // address byte, then detect off, free format, ack expected, trx expected
    logic [11:0] sv_t [4] = '{12'hB53, 12'h002, 12'hB58, 12'hB56};
    assign scl_bus = ~(scl_oe | pm_scl);
    assign sda_bus = ~(sda_oe | pm_sda);

    iacr_core dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_ctrl(ctrl), .i_role_wr(role_wr),
        .i_role_master(role_m), .i_role_transmit(role_t), .i_release(rel), .i_tx_data(txd),
        .i_start_req(start), .i_stop_req(stp), .i_arb_lost(arb), .i_scl_pin(scl_bus),
        .i_sda_pin(sda_bus), .o_master_select(m_sel), .o_transmit_select(t_sel),
        .o_pending(pend), .o_word_done(wdone), .o_rx_byte(rxd), .o_last_bit(),
        .o_bus_busy(), .o_addressed(addr_hit), .o_scl_out(), .o_scl_oe(scl_oe),
        .o_sda_out(), .o_sda_oe(sda_oe));
    iacr_bus_model pm (.i_scl(scl_bus), .i_sda(sda_bus), .o_scl_low(pm_scl), .o_sda_low(pm_sda));

    initial forever #4 i_sys_clk = ~i_sys_clk;
    // pulses drop one edge after they were raised
    always @(posedge i_sys_clk) begin
        if (role_wr) role_wr <= 1'b0;
        if (rel) rel <= 1'b0;
        if (start) start <= 1'b0;
        if (arb) arb <= 1'b0;
        if (stp) stp <= 1'b0;
    end
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end

    // ----
    // tasks
    // ----
    task automatic fail(input string msg);
        miscompares++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) fail(msg);
    endtask
    task automatic chk_cnt(input int got, input int exp, input string msg);
        checked++;
        if (got != exp) fail(msg);
    endtask
    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge i_sys_clk) i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
    endtask
    // 0 word end, 1 data pulled, 2 ack clock high
    task automatic wait_cond(input int w);
        n = 0;
        while (n < 2000 && !(w == 0 ? wdone === 1'b1 : w == 1 ? sda_oe === 1'b1 :
               pm.nbit == 9 && scl_bus === 1'b1)) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n == 2000) fail("wait ran out");
    endtask
    task automatic run_of(input logic lvl, output int len);
        len = 0;
        while (scl_oe === lvl && len < 1000) begin
            @(negedge i_sys_clk);
            len++;
        end
    endtask
    task automatic master_go(input logic [2:0] sel, input logic [7:0] d);
        @(posedge i_sys_clk) ctrl.period_sel <= sel;
        do_reset();
        @(posedge i_sys_clk);
        {role_wr, role_m, role_t, rel} <= 4'hF;
        txd <= d;
        @(posedge i_sys_clk) start <= 1'b1;
    endtask

    // ----
    // sequence
    // ----
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_sys_clk);
        chk_bit(pend, 1'b1, "pending at reset");
        chk_bit(m_sel | t_sel | scl_oe | sda_oe, 1'b0, "roles and pins at reset");
        for (int s = 0; s < 8; s++) begin
            master_go(s[2:0], 8'hA0);
            wait_cond(1);
            run_of(1'b0, n);
            chk_cnt(n, hi_t[s], "start hold");
            run_of(1'b1, n);
            chk_cnt(n, lo_t[s], "low time");
            run_of(1'b0, n);
            chk_cnt(n, hi_t[s] + 3, "high time");
        end
        // direction 1: acked turns to receiver, unacked keeps transmitter
        for (int k = 0; k < 2; k++) begin
            pm.ack_en = ~k[0];
            pm.nbit = 0;
            master_go(3'h0, 8'hA1);
            wait_cond(2);
            chk_bit(sda_oe, 1'b0, "ack slot released");
            wait_cond(0);
            chk_bit(pm.rxb == 8'hA1, 1'b1, "byte on wire");
            chk_bit(t_sel, k[0], "trx after address");
            repeat (20) @(negedge i_sys_clk);
            chk_bit(pend, 1'b0, "pending cleared");
            chk_bit(scl_oe, 1'b1, "clock held low");
        end
        // ack mode off: eight clocks only, then a stop closes the frame
        @(posedge i_sys_clk) ctrl.ack_mode <= 1'b0;
        master_go(3'h0, 8'hA1);
        wait_cond(0);
        repeat (20) @(negedge i_sys_clk);
        chk_cnt(pm.nbit, 8, "clocks without ack");
        @(posedge i_sys_clk) {stp, rel} <= 2'h3;
        run_of(1'b1, n);
        // 3 cycles of level lag, then the high setup time with data held low
        repeat (hi_t[0] + 2) @(negedge i_sys_clk);
        chk_bit(sda_oe, 1'b1, "stop setup hold");
        repeat (20) @(negedge i_sys_clk);
        chk_bit(m_sel | t_sel | sda_oe, 1'b0, "stop clears roles");
        @(posedge i_sys_clk);
        {arb, role_wr, role_m, role_t} <= 4'hF;
        repeat (2) @(negedge i_sys_clk);
        chk_bit(m_sel, 1'b0, "arb clears master");
        chk_bit(t_sel, 1'b0, "arb clears trx");
        @(posedge i_sys_clk);
        {role_wr, role_m, role_t} <= 3'h7;
        repeat (2) @(negedge i_sys_clk);
        chk_bit(m_sel & t_sel, 1'b1, "role write");
        pm.ack_en = 1'b0;
        for (int r = 0; r < 4; r++) begin
            @(posedge i_sys_clk);
            ctrl.ack_mode <= 1'b1;
            ctrl.address_detect_off <= sv_t[r][3];
            ctrl.free_format_sel <= sv_t[r][2];
            do_reset();
            repeat (4) @(posedge i_sys_clk);
            pm.start_frame();
            pm.send_byte(sv_t[r][11:4], ack);
            repeat (10) @(negedge i_sys_clk);
            chk_bit(ack, sv_t[r][1], "slave ack");
            chk_bit(t_sel, sv_t[r][0], "slave trx");
            chk_bit(pend, ~sv_t[r][1], "slave pending");
            pm.free_clk();
            if (sv_t[r][1]) begin
                chk_bit(rxd == sv_t[r][11:4] && addr_hit, 1'b1, "slave byte");
                @(posedge i_sys_clk) rel <= 1'b1;
                // low time counts from the edge where pending is set
                repeat (2) @(negedge i_sys_clk);
                run_of(1'b1, n);
                chk_cnt(n, lo_t[0], "slave low hold");
            end
        end
        close_out();
    end
endmodule

`default_nettype wire
